/* File: rfl_core.sv */
`timescale 1ns/10ps
// What this block does
// - nonzero bit limit ends reception after that many bits; zero means stop on pause
// - commands 98 to 9C force the receive bit limit to 16
// - command 9F forces the receive bit limit to 32
// - bit limit low byte clears on reset, chip enable low, successful reception end
// - during reception flag high level once 18 bytes are held
// - during transmission flag low level when only 6 bytes remain
// - overflow flag in status bit 5 on write into a full fifo
// - five low status bits give the unread byte count
// - 12-bit tx byte count: upper eight in 1D, lowest four in 1E bits 7..4
// - tx count high register clears on reset, enable low and tx end of frame
// - partial byte bit count is used only when the partial flag is set
// - bit 0 of 1E set means the last byte is shorter than 8 bits
// - 1E write value drives sending but is never read back
// - 1E bits 4..0 read the valid bit count of the last received byte
// - incomplete final received byte keeps its valid bits at the lsb end
// - 24-byte circular fifo at 1F with wrapping write and read pointers
// - fifo count and overflow flag clear on reset and while chip enable is low
// - sending starts at the third fifo byte, or when a short message is loaded
// - fifo reset command clears pointers and count, and the overflow flag unless a write overflows in that cycle
// - receive limit bits 9 and 8 come from the neighbouring length register
module rfl_core #(
  parameter int unsigned DEPTH = rfl_pkg::FIFO_DEPTH
) (
  input  wire logic                      clock,
  input  wire logic                      sys_rst,
  input  wire logic                      chip_en,
  input  wire logic [rfl_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [7:0]                reg_wdata,
  output logic      [7:0]                reg_rdata,
  input  wire logic                      cmd_valid,
  input  wire logic [7:0]                cmd_code,
  input  wire logic [1:0]                rx_limit_high,
  input  wire logic                      rx_active,
  input  wire logic                      rx_byte_valid,
  input  wire logic [7:0]                rx_byte,
  input  wire logic                      rx_byte_last,
  input  wire logic [2:0]                rx_byte_bits,
  input  wire logic                      rx_done_ok,
  input  wire logic [4:0]                rx_last_bits,
  output logic      [9:0]                rx_bit_limit,
  output logic                           rx_stop_on_pause,
  input  wire logic                      tx_active,
  input  wire logic                      tx_byte_req,
  input  wire logic                      tx_eof,
  output logic                           tx_start,
  output logic      [7:0]                tx_data,
  output logic                           tx_data_valid,
  output rfl_pkg::rfl_tx_len_t           tx_len,
  output logic                           fifo_reset_pulse
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam logic [PW-1:0] LAST_IDX = PW'(DEPTH - 1);
  localparam logic [4:0] CNT_FULL = 5'(DEPTH);
  localparam logic [4:0] CNT_HIGH = 5'(rfl_pkg::FIFO_HIGH_LEVEL);
  localparam logic [4:0] CNT_LOW  = 5'(rfl_pkg::FIFO_LOW_LEVEL);
  localparam logic [4:0] CNT_GO   = 5'(rfl_pkg::TX_START_BYTES);

  // chip enable is a pin: two flops before use
  logic en_meta_r;
  logic en_r;
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      en_meta_r <= 1'b0;
      en_r      <= 1'b0;
    end
    else
    begin
      en_meta_r <= chip_en;
      en_r      <= en_meta_r;
    end

  wire clr = !en_r;

  logic [7:0]           limit_low_r;
  logic [7:0]           count_high_r;
  logic [7:0]           count_low_r;
  logic [4:0]           rx_bits_r;
  logic [9:0]           forced_limit_r;
  logic                 forced_r;
  logic [7:0]           mem_r [DEPTH];
  logic [PW-1:0]        wp_r;
  logic [PW-1:0]        rp_r;
  logic [4:0]           cnt_r;
  logic                 ovf_r;
  logic                 tx_pend_r;

  wire wr_limit  = reg_wr && reg_addr == rfl_pkg::ADR_RX_LIMIT_LOW;
  wire wr_high   = reg_wr && reg_addr == rfl_pkg::ADR_TX_COUNT_HIGH;
  wire wr_low    = reg_wr && reg_addr == rfl_pkg::ADR_TX_COUNT_LOW;
  wire wr_fifo   = reg_wr && reg_addr == rfl_pkg::ADR_FIFO_DATA;
  wire rd_fifo   = reg_rd && reg_addr == rfl_pkg::ADR_FIFO_DATA;
  wire cmd_reset = cmd_valid && cmd_code == rfl_pkg::CMD_FIFO_RESET;
  wire cmd_query = cmd_valid && cmd_code >= rfl_pkg::CMD_QUERY_FIRST
                   && cmd_code <= rfl_pkg::CMD_QUERY_LAST;
  wire cmd_rn    = cmd_valid && cmd_code == rfl_pkg::CMD_REQ_HANDLE;
  wire cmd_tx    = cmd_valid && ((cmd_code >= rfl_pkg::CMD_TX_FIRST
                   && cmd_code <= rfl_pkg::CMD_TX_LAST) || cmd_query || cmd_rn);

  wire full  = cnt_r == CNT_FULL;
  wire empty = cnt_r == 5'h00;

  // the decoder has priority; a host write in the same cycle is dropped
  wire       push_req  = rx_byte_valid || wr_fifo;
  wire [7:0] push_byte_raw = rx_byte_valid ? rx_byte : reg_wdata;
  wire       partial_in = rx_byte_valid && rx_byte_last && rx_byte_bits != 3'h0;
  wire [3:0] shift_amt = 4'h8 - {1'b0, rx_byte_bits};
  wire [7:0] push_byte = partial_in ? push_byte_raw >> shift_amt : push_byte_raw;
  wire       push      = push_req && !full;
  wire       pop_host  = rd_fifo && !empty;
  wire       pop_tx    = tx_byte_req && !empty && !rd_fifo;
  wire       pop       = pop_host || pop_tx;
  wire [PW-1:0] wp_nxt = wp_r == LAST_IDX ? '0 : wp_r + 1'b1;
  wire [PW-1:0] rp_nxt = rp_r == LAST_IDX ? '0 : rp_r + 1'b1;
  wire [4:0] cnt_nxt   = 5'(cnt_r + {4'h0, push} - {4'h0, pop});

  // the struct carries count, bits and flag; bits are masked when flag is off
  assign tx_len.tx_complete_byte_count = {count_high_r, count_low_r[7:rfl_pkg::TXL_COUNT_LSB]};
  assign tx_len.partial = count_low_r[rfl_pkg::TXL_PARTIAL_BIT];
  assign tx_len.partial_byte_bits = tx_len.partial ?
    count_low_r[rfl_pkg::TXL_BITS_LSB +: 3] : 3'h0;

  wire [12:0] msg_bytes = {1'b0, tx_len.tx_complete_byte_count} + {12'h000, tx_len.partial};
  wire        loaded    = {8'h00, cnt_r} >= msg_bytes;
  wire        go        = tx_pend_r && (cnt_r >= CNT_GO || loaded);

  assign rx_bit_limit = forced_r ? forced_limit_r : {rx_limit_high, limit_low_r};
  assign rx_stop_on_pause = rx_bit_limit == 10'h000;

  wire hi_flag = rx_active && cnt_r >= CNT_HIGH;
  wire lo_flag = tx_active && cnt_r <= CNT_LOW;
  wire [7:0] status = {hi_flag, lo_flag, ovf_r, cnt_r};

  logic [7:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      rfl_pkg::ADR_RX_LIMIT_LOW:  rd_mux = limit_low_r;
      rfl_pkg::ADR_FIFO_FLAGS:    rd_mux = status;
      rfl_pkg::ADR_TX_COUNT_HIGH: rd_mux = count_high_r;
      rfl_pkg::ADR_TX_COUNT_LOW:  rd_mux = {3'h0, rx_bits_r};
      rfl_pkg::ADR_FIFO_DATA:     rd_mux = empty ? 8'h00 : mem_r[rp_r];
      default:                    rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      reg_rdata <= rfl_pkg::RST_BYTE;
    else if (reg_rd)
      reg_rdata <= rd_mux;

  // length and limit registers
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      limit_low_r  <= rfl_pkg::RST_BYTE;
      count_high_r <= rfl_pkg::RST_BYTE;
      count_low_r  <= rfl_pkg::RST_BYTE;
      rx_bits_r    <= 5'h00;
    end
    else if (clr)
    begin
      limit_low_r  <= rfl_pkg::RST_BYTE;
      count_high_r <= rfl_pkg::RST_BYTE;
      count_low_r  <= rfl_pkg::RST_BYTE;
      rx_bits_r    <= 5'h00;
    end
    else
    begin
      if (wr_limit)
        limit_low_r <= reg_wdata;
      else if (rx_done_ok)
        limit_low_r <= rfl_pkg::RST_BYTE;
      if (wr_high)
        count_high_r <= reg_wdata;
      else if (tx_eof)
        count_high_r <= rfl_pkg::RST_BYTE;
      if (wr_low)
        count_low_r <= reg_wdata;
      if (rx_done_ok)
        rx_bits_r <= rx_last_bits;
    end

  // a forced limit lasts until the reception it was meant for ends
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      forced_r       <= 1'b0;
      forced_limit_r <= 10'h000;
    end
    else if (clr)
      forced_r <= 1'b0;
    else if (cmd_query || cmd_rn)
    begin
      forced_r       <= 1'b1;
      forced_limit_r <= cmd_rn ? rfl_pkg::LIMIT_REQ_HANDLE : rfl_pkg::LIMIT_QUERY;
    end
    else if (rx_done_ok)
      forced_r <= 1'b0;

  // fifo storage, one flop row per entry
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_mem
    always_ff @(posedge clock)
      if (push && wp_r == PW'(i))
        mem_r[i] <= push_byte;
  end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= 5'h00;
      ovf_r <= 1'b0;
    end
    else if (clr || cmd_reset)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= 5'h00;
      // an overflow in the reset cycle survives, so the host still learns of the lost byte
      ovf_r <= !clr && push_req && full;
    end
    else
    begin
      if (push)
        wp_r <= wp_nxt;
      if (pop)
        rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      if (push_req && full)
        ovf_r <= 1'b1;
    end

  // transmit side: start and byte hand-off
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      tx_pend_r     <= 1'b0;
      tx_start      <= 1'b0;
      tx_data       <= 8'h00;
      tx_data_valid <= 1'b0;
    end
    else if (clr)
    begin
      tx_pend_r     <= 1'b0;
      tx_start      <= 1'b0;
      tx_data_valid <= 1'b0;
    end
    else
    begin
      tx_start      <= go;
      tx_pend_r     <= cmd_tx || (tx_pend_r && !go);
      tx_data_valid <= pop_tx;
      if (pop_tx)
        tx_data <= mem_r[rp_r];
    end

  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
      fifo_reset_pulse <= 1'b0;
    else
      fifo_reset_pulse <= cmd_reset && !clr;

  count_range_a: assert property (@(posedge clock) disable iff (sys_rst)
    cnt_r <= CNT_FULL)
    else $error("fifo count above depth");

  count_track_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && !cmd_reset && push && !pop) |=> cnt_r == $past(cnt_r) + 5'h01)
    else $error("count did not follow a push");

  ovf_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && push_req && full) |=> status[rfl_pkg::FLAG_OVF_BIT])
    else $error("overflow flag not set");

  ovf_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (ovf_r && en_r && !cmd_reset) |=> ovf_r)
    else $error("overflow flag lost before fifo reset");

  discard_wr_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && !cmd_reset && push_req && full) |=> $stable(wp_r))
    else $error("write into a full fifo moved the pointer");

  clear_en_a: assert property (@(posedge clock) disable iff (sys_rst)
    !en_r |=> status[5:0] == 6'h00 && limit_low_r == 8'h00 && count_high_r == 8'h00)
    else $error("state not cleared by chip enable low");

  flag_level_a: assert property (@(posedge clock) disable iff (sys_rst)
    status[rfl_pkg::FLAG_HIGH_BIT] == (rx_active && cnt_r >= CNT_HIGH))
    else $error("high level flag wrong");

  low_level_a: assert property (@(posedge clock) disable iff (sys_rst)
    status[rfl_pkg::FLAG_LOW_BIT] == (tx_active && cnt_r <= CNT_LOW))
    else $error("low level flag wrong");

  forced_lim_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && cmd_rn) |=> rx_bit_limit == rfl_pkg::LIMIT_REQ_HANDLE)
    else $error("request handle limit not 32");

  query_lim_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && cmd_query) |=> rx_bit_limit == rfl_pkg::LIMIT_QUERY)
    else $error("query limit not 16");

  eof_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    (tx_eof && !wr_high) |=> count_high_r == 8'h00)
    else $error("tx count high not cleared at end of frame");

  rx_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && rx_done_ok && !wr_limit) |=> limit_low_r == 8'h00 && rx_bits_r == $past(rx_last_bits))
    else $error("reception end bookkeeping wrong");

  tx_go_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && tx_pend_r && cnt_r >= CNT_GO) |=> tx_start && (!tx_pend_r || $past(cmd_tx)))
    else $error("transmit did not start at third byte");

  ptr_wrap_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && !cmd_reset && push && wp_r == LAST_IDX) |=> wp_r == '0)
    else $error("write pointer did not wrap");

  fifo_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && cmd_reset) |=> cnt_r == 5'h00 && wp_r == '0 && rp_r == '0)
    else $error("fifo reset left pointers or count");

  tx_short_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && tx_pend_r && loaded) |=> tx_start)
    else $error("short message did not start once loaded");

  len_read_a: assert property (@(posedge clock) disable iff (sys_rst)
    (reg_rd && reg_addr == rfl_pkg::ADR_TX_COUNT_LOW) |=> reg_rdata == {3'h0, $past(rx_bits_r)})
    else $error("length byte two read wrong");

  tx_hand_a: assert property (@(posedge clock) disable iff (sys_rst)
    (en_r && pop_tx) |=> tx_data_valid && tx_data == $past(mem_r[rp_r]))
    else $error("coder byte not handed over in order");

endmodule

/* File: rfl_pkg.sv */
package rfl_pkg;

  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;

  localparam logic [5:0] ADR_RX_LIMIT_LOW   = 6'h1B;
  localparam logic [5:0] ADR_FIFO_FLAGS     = 6'h1C;
  localparam logic [5:0] ADR_TX_COUNT_HIGH  = 6'h1D;
  localparam logic [5:0] ADR_TX_COUNT_LOW   = 6'h1E;
  localparam logic [5:0] ADR_FIFO_DATA      = 6'h1F;

  localparam logic [7:0] RST_BYTE           = 8'h00;

  localparam int unsigned FIFO_DEPTH        = 24;
  localparam int unsigned FIFO_HIGH_LEVEL   = 18;
  localparam int unsigned FIFO_LOW_LEVEL    = 6;
  localparam int unsigned TX_START_BYTES    = 3;

  localparam int unsigned FLAG_HIGH_BIT     = 7;
  localparam int unsigned FLAG_LOW_BIT      = 6;
  localparam int unsigned FLAG_OVF_BIT      = 5;

  localparam int unsigned TXL_COUNT_LSB     = 4;
  localparam int unsigned TXL_BITS_LSB      = 1;
  localparam int unsigned TXL_PARTIAL_BIT   = 0;

  localparam logic [9:0] LIMIT_QUERY        = 10'h010;
  localparam logic [9:0] LIMIT_REQ_HANDLE   = 10'h020;

  localparam logic [7:0] CMD_FIFO_RESET     = 8'h8F;
  localparam logic [7:0] CMD_TX_FIRST       = 8'h90;
  localparam logic [7:0] CMD_TX_LAST        = 8'h94;
  localparam logic [7:0] CMD_QUERY_FIRST    = 8'h98;
  localparam logic [7:0] CMD_QUERY_LAST     = 8'h9C;
  localparam logic [7:0] CMD_REQ_HANDLE     = 8'h9F;

  typedef struct packed {
    logic [11:0] tx_complete_byte_count;
    logic [2:0]  partial_byte_bits;
    logic        partial;
  } rfl_tx_len_t;

endpackage

/* File: rfl_host_model.sv */
`timescale 1ns/10ps
module rfl_host_model (
  input  wire logic       clock,
  output logic      [5:0] reg_addr = 6'h00,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00
);
  // a released bus shows the inverse, so late sampling by the device reads garbage
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clock);
    {reg_addr, reg_rd} <= {~a, 1'b0};
  endtask
  // lengths go in ahead of the frame data so sending never sees a stale count
  task automatic set_len(input logic [11:0] n);
    wr(6'h1D, n[11:4]);
    wr(6'h1E, {n[3:0], 4'h0});
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic       clock = 1'b0, sys_rst = 1'b1, chip_en = 1'b1, cmd_valid = 1'b0;
  logic       rx_active = 1'b0, rx_byte_valid = 1'b0, rx_byte_last = 1'b0, rx_done_ok = 1'b0;
  logic       tx_active = 1'b0, tx_byte_req = 1'b0, tx_eof = 1'b0, rd_d = 1'b0;
  logic       reg_wr, reg_rd, rx_stop_on_pause, tx_start, tx_data_valid, fifo_reset_pulse;
  logic [1:0] rx_limit_high = 2'h0;
  logic [2:0] rx_byte_bits = 3'h0;
  logic [4:0] rx_last_bits = 5'h00, lb;
  logic [5:0] reg_addr;
  logic [7:0] cmd_code = 8'h00, rx_byte = 8'h00, reg_wdata, reg_rdata, tx_data, v;
  logic [7:0] b [0:23];
  logic [7:0] rq [$], tq [$];
  logic [9:0] rx_bit_limit;
  int         fail_count = 0, checks_done = 0, starts = 0, pulses = 0, k;
  rfl_pkg::rfl_tx_len_t tx_len;

  always #25 clock = ~clock;

  rfl_core #(.DEPTH(24)) DUT (
    .clock, .sys_rst, .chip_en, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .cmd_valid, .cmd_code, .rx_limit_high, .rx_active, .rx_byte_valid, .rx_byte,
    .rx_byte_last, .rx_byte_bits, .rx_done_ok, .rx_last_bits, .rx_bit_limit,
    .rx_stop_on_pause, .tx_active, .tx_byte_req, .tx_eof, .tx_start, .tx_data,
    .tx_data_valid, .tx_len, .fifo_reset_pulse
  );
  rfl_host_model host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // expectation is queued before the strobe so the monitor never runs dry
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    rq.push_back(e);
    host.rd(a);
  endtask

  // 0 pops a byte for the coder, 1 ends a tx frame, 2 ends a reception, 3 a command
  task automatic pulse(input int p, input logic [7:0] c = 8'h00);
    @(posedge clock);
    {tx_byte_req, tx_eof, rx_done_ok, cmd_valid} <= {p == 0, p == 1, p == 2, p == 3};
    cmd_code <= c;
    @(posedge clock);
    {tx_byte_req, tx_eof, rx_done_ok, cmd_valid} <= 4'h0;
  endtask

  always @(posedge clock)
  begin
    rd_d <= reg_rd;
    if (tx_start === 1'b1)
      starts <= starts + 1;
    if (fifo_reset_pulse === 1'b1)
      pulses <= pulses + 1;
  end

  // looked at mid-cycle, clear of the edge where the registered outputs move
  always @(negedge clock)
  begin
    if (rd_d)
      chk("reg_rdata", {8'h00, reg_rdata}, {8'h00, rq.size() ? rq.pop_front() : 8'hXX});
    if (tx_data_valid === 1'b1)
      chk("tx_data", {8'h00, tx_data}, {8'h00, tq.size() ? tq.pop_front() : 8'hXX});
  end

  initial
  begin
    #200000;
    fail_count++;
    results;
  end

  initial
  begin
    v = 8'($urandom(32'hC9DB9CDE));
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    host.wr(6'h1C, 8'hFF);
    rd(6'h1B, 8'h00);
    rd(6'h1C, 8'h00);
    rd(6'h1D, 8'h00);
    rd(6'h1E, 8'h00);
    rd(6'h05, 8'h00);
    v = 8'($urandom_range(255, 1));
    rx_limit_high <= 2'h2;
    host.wr(6'h1B, v);
    rd(6'h1B, v);
    @(negedge clock);
    chk("rx_bit_limit", {6'h00, rx_bit_limit}, {6'h00, 2'h2, v});
    chk("stop_on_pause", 16'(rx_stop_on_pause), 16'h0000);
    @(posedge clock);
    rx_limit_high <= 2'h0;
    host.wr(6'h1B, 8'h00);
    @(negedge clock);
    chk("stop_on_pause", 16'(rx_stop_on_pause), 16'h0001);
    for (int c = 'h98; c <= 'h9F; c++)
    begin
      if (c == 'h9D || c == 'h9E)
        continue;
      host.wr(6'h1B, 8'h07);
      pulse(3, c[7:0]);
      @(negedge clock);
      chk("forced_limit", 16'(rx_bit_limit), (c == 'h9F) ? 16'h0020 : 16'h0010);
      @(posedge clock);
      lb = 5'($urandom_range(8, 1));
      rx_last_bits <= lb;
      pulse(2);
      @(negedge clock);
      chk("limit_cleared", 16'(rx_bit_limit), 16'h0000);
      v = 8'($urandom);
      host.wr(6'h1E, v);
      @(negedge clock);
      chk("tx_len", tx_len, {8'h00, v[7:4], v[0] ? v[3:1] : 3'h0, v[0]});
      rd(6'h1E, {3'h0, lb});
    end
    // a chip enable drop also throws away any transmit left armed above
    host.wr(6'h1D, 8'h5A);
    host.wr(6'h1B, 8'h33);
    host.wr(6'h1F, 8'h11);
    @(posedge clock);
    chip_en <= 1'b0;
    repeat (4) @(posedge clock);
    chip_en <= 1'b1;
    repeat (3) @(posedge clock);
    rd(6'h1B, 8'h00);
    rd(6'h1C, 8'h00);
    rd(6'h1D, 8'h00);
    for (int n = 10; n <= 24; n += 14)
    begin
      for (int i = 0; i < n; i++)
      begin
        b[i] = 8'($urandom);
        host.wr(6'h1F, b[i]);
      end
      rd(6'h1C, 8'(n));
      if (n == 24)
      begin
        host.wr(6'h1F, 8'hEE);
        rd(6'h1C, 8'h38);
      end
      for (int i = 0; i < n; i++)
        rd(6'h1F, b[i]);
      rd(6'h1F, 8'h00);
    end
    rd(6'h1C, 8'h20);
    pulse(3, 8'h8F);
    rd(6'h1C, 8'h00);
    chk("reset_pulses", 16'(pulses), 16'h0001);
    @(posedge clock);
    rx_active <= 1'b1;
    for (int i = 0; i < 18; i++)
    begin
      b[i] = (i == 17) ? 8'h05 : 8'($urandom);
      if (i == 17)
        rd(6'h1C, 8'h11);
      @(posedge clock);
      rx_byte_valid <= 1'b1;
      rx_byte <= (i == 17) ? 8'hA0 : b[i];
      rx_byte_last <= (i == 17);
      rx_byte_bits <= (i == 17) ? 3'h3 : 3'h0;
      @(posedge clock);
      {rx_byte_valid, rx_byte} <= {1'b0, ~rx_byte};
    end
    rd(6'h1C, 8'h92);
    for (int i = 0; i < 18; i++)
      rd(6'h1F, b[i]);
    @(posedge clock);
    rx_active <= 1'b0;
    for (int n = 3; n >= 2; n--)
    begin
      host.set_len(12'(n));
      pulse(3, 8'h93 - 8'(n));
      k = starts;
      for (int i = 0; i < n; i++)
      begin
        repeat (2) @(posedge clock);
        chk("tx_start_early", 16'(starts), 16'(k));
        b[i] = 8'($urandom);
        host.wr(6'h1F, b[i]);
      end
      repeat (3) @(posedge clock);
      chk("tx_start", 16'(starts), 16'(k + 1));
      tx_active <= 1'b1;
      rd(6'h1C, 8'h40 + 8'(n));
      for (int i = 0; i < n; i++)
      begin
        tq.push_back(b[i]);
        pulse(0);
      end
      host.wr(6'h1D, 8'h5A);
      pulse(1);
      rd(6'h1D, 8'h00);
      tx_active <= 1'b0;
    end
    repeat (4) @(posedge clock);
    chk("tx_bytes_left", 16'(tq.size()), 16'h0000);
    results;
  end
endmodule
